/* cmc_map.svh */
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH

// Register indices; byte address is four times the index
`define CMC_REG_CTRL_IDX 4'h0
`define CMC_REG_STATUS_IDX 4'h1
`define CMC_REG_RANGE_I_IDX 4'h3
`define CMC_REG_RANGE_Q_IDX 4'hB
`define CMC_REG_REFCLK_IDX 4'hE

// Control register fields
`define CMC_CTRL_SELFTRIM_BIT 15
`define CMC_CTRL_PHASE_BIT 14
`define CMC_CTRL_PATTERN_BIT 12
`define CMC_CTRL_PD_I_BIT 11
`define CMC_CTRL_PD_Q_BIT 10
`define CMC_CTRL_DES_BIT 7
`define CMC_CTRL_DES_Q_BIT 6

// Reference clock register fields
`define CMC_REFCLK_SYNC_EN_BIT 0
`define CMC_REFCLK_OUT_EN_BIT 1
`define CMC_REFCLK_SLAVE_BIT 2
`define CMC_REFCLK_DELAY_LSB 8
`define CMC_REFCLK_DELAY_MSB 11

// Reset values
`define CMC_CTRL_RST 16'h0000
`define CMC_RANGE_RST 16'h8000
`define CMC_REFCLK_RST 16'h0000
`define CMC_RANGE_MIN 16'h0000
`define CMC_RANGE_MID 16'h8000

// Pin vector positions
`define CMC_PIN_DES 0
`define CMC_PIN_WAIT 1
`define CMC_PIN_TRIG 2
`define CMC_PIN_PD_I 3
`define CMC_PIN_PD_Q 4
`define CMC_PIN_PATTERN 5
`define CMC_PIN_BYPASS 6
`define CMC_PIN_RANGE 7
`define CMC_PIN_PHASE 8
`define CMC_PIN_ECE_N 9
`define CMC_PIN_REFIN 10
`define CMC_PIN_N 11

// Timing
`define CMC_CLK_MHZ 250
`define CMC_TRIG_LOW_MIN_NS 40
`define CMC_TRIG_HIGH_MIN_NS 40
`define CMC_WAIT_SHORT_NS 16000
`define CMC_WAIT_LONG_NS 1000000
`define CMC_CAL_RUN_NS 100000
`define CMC_PWRUP_NS 1000
`define CMC_TRIG_LOW_MIN_CYC ((`CMC_TRIG_LOW_MIN_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_TRIG_HIGH_MIN_CYC ((`CMC_TRIG_HIGH_MIN_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_WAIT_SHORT_CYC ((`CMC_WAIT_SHORT_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_WAIT_LONG_CYC ((`CMC_WAIT_LONG_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_CAL_RUN_CYC ((`CMC_CAL_RUN_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_PWRUP_CYC ((`CMC_PWRUP_NS * `CMC_CLK_MHZ + 999) / 1000)
// Must cover the three pin stages plus the filter edge, or the request level is judged stale
`define CMC_SETTLE_CYC 4
`define CMC_CNT_W 24

`endif

/* cmc_mode_ctrl.sv */
`timescale 1ns/1ps
`include "cmc_map.svh"
// Functional notes
// [RULE_01] Reference outputs run at quarter sampling rate
// [RULE_02] Reference outputs gated by enable bit, off
// [RULE_03] Slave sync aligns divider to delayed reference
// [RULE_04] Pin selects interleaved or independent channels
// [RULE_05] Extended mode takes interleave from register
// [RULE_06] Wait pin picks long or short delay
// [RULE_07] Low then high request runs one calibration
// [RULE_08] Request high at power-on suppresses auto-calibration
// [RULE_09] Extended mode ORs request pin with bit
// [RULE_10] Running flag high exactly during calibration
// [RULE_11] Power-down pins; release after finite delay
// [RULE_12] Extended mode ORs power-down pins with bits
// [RULE_13] Pattern pin selects repeating test pattern
// [RULE_14] Extended mode takes pattern from register only
// [RULE_15] Bypass pin alone selects output demux ratio
// [RULE_16] Range pin or per-channel range registers
// [RULE_17] Phase pin selects 0 or 90 degrees
// [RULE_18] Extended mode takes phase from register
// [RULE_19] Enable-low selects extended mode, else defaults
// [RULE_20] All control pins synchronised before use
module cmc_mode_ctrl
	import cmc_pkg::*;
#(
	parameter int WAIT_SHORT_CYC = `CMC_WAIT_SHORT_CYC,
	parameter int WAIT_LONG_CYC = `CMC_WAIT_LONG_CYC,
	parameter int CAL_RUN_CYC = `CMC_CAL_RUN_CYC,
	parameter int PWRUP_CYC = `CMC_PWRUP_CYC
)
(
	input wire logic clk_sys, // Sampling clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [5:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic dual_edge_sampling_select, // Interleave pin
	input wire logic selftrim_wait_select, // Long power-on wait pin
	input wire logic selftrim_request, // Calibration request pin
	input wire logic power_down_i, // I channel power-down pin
	input wire logic power_down_q, // Q channel power-down pin
	input wire logic pattern_output_select, // Test pattern pin
	input wire logic output_demux_bypass, // 1:1 output bus pin
	input wire logic input_range_select, // Full-scale range pin
	input wire logic output_phase_select, // 90 degree phase pin
	input wire logic extended_control_enable_n, // Extended mode, active low
	input wire logic reference_clock_in, // Multi-chip reference clock
	output logic selftrim_running, // Calibration in progress
	output logic ref_clock_out_a, // Reference clock out A
	output logic ref_clock_out_b, // Reference clock out B
	output logic [1:0] divided_clock_phase, // Internal divide-by-4 phase
	output cmc_mode_t mode_o // Resolved operating mode
);

	initial
	begin
		if (WAIT_SHORT_CYC < 1 || WAIT_LONG_CYC < WAIT_SHORT_CYC
			|| CAL_RUN_CYC < 1 || PWRUP_CYC < 1
			|| WAIT_LONG_CYC >= (1 << `CMC_CNT_W) || CAL_RUN_CYC >= (1 << `CMC_CNT_W)
			|| PWRUP_CYC >= (1 << 16))
			$error("cmc_mode_ctrl: timing parameter out of range");
	end

	localparam logic [`CMC_CNT_W-1:0] WAIT_SHORT = `CMC_CNT_W'(WAIT_SHORT_CYC);
	localparam logic [`CMC_CNT_W-1:0] WAIT_LONG = `CMC_CNT_W'(WAIT_LONG_CYC);
	localparam logic [`CMC_CNT_W-1:0] CAL_RUN = `CMC_CNT_W'(CAL_RUN_CYC);
	localparam logic [`CMC_CNT_W-1:0] LOW_MIN = `CMC_CNT_W'(`CMC_TRIG_LOW_MIN_CYC);
	localparam logic [`CMC_CNT_W-1:0] HIGH_MIN = `CMC_CNT_W'(`CMC_TRIG_HIGH_MIN_CYC);
	localparam logic [`CMC_CNT_W-1:0] SETTLE = `CMC_CNT_W'(`CMC_SETTLE_CYC);
	localparam logic [15:0] PWRUP = 16'(PWRUP_CYC);

	cmc_state_t st_reg;
	cmc_state_t st_next;
	cmc_wb_req_t req;
	logic [`CMC_PIN_N-1:0] pins;
	logic [`CMC_PIN_N-1:0] pin_filt;

	assign pins = {reference_clock_in, extended_control_enable_n, output_phase_select,
		input_range_select, output_demux_bypass, pattern_output_select, power_down_q,
		power_down_i, selftrim_request, selftrim_wait_select, dual_edge_sampling_select};
	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
		sel: wb_sel_i, dat: wb_dat_i};

	// A pin change is accepted only once the second and third stages agree
	genvar k;
	generate
		for (k = 0; k < `CMC_PIN_N; k++)
		begin : g_pin
			assign pin_filt[k] = (st_reg.s2[k] == st_reg.s3[k]) ? st_reg.s3[k] : st_reg.stable[k]; // RULE_20
		end
	endgenerate

	always_comb
	begin
		logic extended_control_mode;
		logic trig;
		logic ref_rise;
		logic wr;
		logic [3:0] idx;
		logic [15:0] wmask;
		logic [15:0] rdat;
		logic ref_on;
		extended_control_mode = 1'b0;
		trig = 1'b0;
		ref_rise = 1'b0;
		wr = 1'b0;
		idx = 4'h0;
		wmask = 16'h0000;
		rdat = 16'h0000;
		ref_on = 1'b0;
		st_next = st_reg;

		st_next.s1 = pins; // RULE_20
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.stable = pin_filt;

		extended_control_mode = ~st_reg.stable[`CMC_PIN_ECE_N]; // RULE_19

		// Register bus: one wait state, then ack for a single cycle
		// A master that keeps its strobe up is acked only every other cycle
		idx = req.adr[5:2];
		wmask = {{8{req.sel[1]}}, {8{req.sel[0]}}};
		st_next.ack = req.cyc & req.stb & ~st_reg.ack;
		wr = st_next.ack & req.we & extended_control_mode;
		if (wr)
		begin
			case (idx)
				`CMC_REG_CTRL_IDX: st_next.ctrl = (st_reg.ctrl & ~wmask) | (req.dat[15:0] & wmask);
				`CMC_REG_RANGE_I_IDX:
					st_next.range_i = (st_reg.range_i & ~wmask) | (req.dat[15:0] & wmask);
				`CMC_REG_RANGE_Q_IDX:
					st_next.range_q = (st_reg.range_q & ~wmask) | (req.dat[15:0] & wmask);
				`CMC_REG_REFCLK_IDX:
					st_next.refclk = (st_reg.refclk & ~wmask) | (req.dat[15:0] & wmask);
				default: ;
			endcase
		end
		case (idx)
			`CMC_REG_CTRL_IDX: rdat = st_reg.ctrl;
			`CMC_REG_STATUS_IDX: rdat = {8'h00, st_reg.mode.extended_control_mode, st_reg.mode.ready_q,
				st_reg.mode.ready_i, st_reg.mode.phase90, st_reg.mode.bypass,
				st_reg.mode.pattern, st_reg.mode.interleave, st_reg.running};
			`CMC_REG_RANGE_I_IDX: rdat = st_reg.range_i;
			`CMC_REG_RANGE_Q_IDX: rdat = st_reg.range_q;
			`CMC_REG_REFCLK_IDX: rdat = st_reg.refclk;
			default: rdat = 16'h0000;
		endcase
		st_next.dat = st_next.ack ? {16'h0000, rdat} : 32'h0000_0000;

		// Leaving extended mode returns every register to its default
		if (!extended_control_mode)
		begin
			st_next.ctrl = `CMC_CTRL_RST; // RULE_19
			st_next.range_i = `CMC_RANGE_RST;
			st_next.range_q = `CMC_RANGE_RST;
			st_next.refclk = `CMC_REFCLK_RST;
		end

		// Mode resolution
		st_next.mode.extended_control_mode = extended_control_mode;
		st_next.mode.interleave = extended_control_mode ? st_reg.ctrl[`CMC_CTRL_DES_BIT] // RULE_05
			: st_reg.stable[`CMC_PIN_DES]; // RULE_04
		st_next.mode.des_q = extended_control_mode & st_reg.ctrl[`CMC_CTRL_DES_Q_BIT];
		st_next.mode.pattern = extended_control_mode ? st_reg.ctrl[`CMC_CTRL_PATTERN_BIT] // RULE_14
			: st_reg.stable[`CMC_PIN_PATTERN]; // RULE_13
		st_next.mode.bypass = st_reg.stable[`CMC_PIN_BYPASS]; // RULE_15
		// Phase only matters on the 1:2 bus; forced to 0 degrees on 1:1
		st_next.mode.phase90 = ~st_reg.stable[`CMC_PIN_BYPASS] & (extended_control_mode // RULE_17
			? st_reg.ctrl[`CMC_CTRL_PHASE_BIT] // RULE_18
			: st_reg.stable[`CMC_PIN_PHASE]);
		if (extended_control_mode)
		begin
			st_next.mode.range_i = st_reg.range_i; // RULE_16
			st_next.mode.range_q = st_reg.range_q;
		end
		else
		begin
			st_next.mode.range_i = st_reg.stable[`CMC_PIN_RANGE] ? `CMC_RANGE_MID
				: `CMC_RANGE_MIN; // RULE_16
			st_next.mode.range_q = st_next.mode.range_i;
		end
		st_next.mode.pd_i = st_reg.stable[`CMC_PIN_PD_I]
			| (extended_control_mode & st_reg.ctrl[`CMC_CTRL_PD_I_BIT]); // RULE_11 RULE_12
		st_next.mode.pd_q = st_reg.stable[`CMC_PIN_PD_Q]
			| (extended_control_mode & st_reg.ctrl[`CMC_CTRL_PD_Q_BIT]); // RULE_11 RULE_12

		// Channel returns to operation a fixed delay after power-down drops
		if (st_reg.mode.pd_i)
		begin
			st_next.pwr_cnt_i = 16'h0000;
			st_next.mode.ready_i = 1'b0;
		end
		else if (st_reg.pwr_cnt_i >= PWRUP)
			st_next.mode.ready_i = 1'b1; // RULE_11
		else
			st_next.pwr_cnt_i = st_reg.pwr_cnt_i + 16'h0001;
		if (st_reg.mode.pd_q)
		begin
			st_next.pwr_cnt_q = 16'h0000;
			st_next.mode.ready_q = 1'b0;
		end
		else if (st_reg.pwr_cnt_q >= PWRUP)
			st_next.mode.ready_q = 1'b1; // RULE_11
		else
			st_next.pwr_cnt_q = st_reg.pwr_cnt_q + 16'h0001;

		// Calibration request: pin ORed with the register bit in extended mode
		trig = st_reg.stable[`CMC_PIN_TRIG] | (extended_control_mode & st_reg.ctrl[`CMC_CTRL_SELFTRIM_BIT]); // RULE_09
		if (trig)
			st_next.low_cnt = '0;
		else if (st_reg.low_cnt < LOW_MIN)
			st_next.low_cnt = st_reg.low_cnt + `CMC_CNT_W'(1);
		if (!trig)
			st_next.high_cnt = '0;
		else if (st_reg.armed && st_reg.high_cnt < HIGH_MIN)
			st_next.high_cnt = st_reg.high_cnt + `CMC_CNT_W'(1);
		if (!trig && st_next.low_cnt >= LOW_MIN)
			st_next.armed = 1'b1; // RULE_07

		case (st_reg.cal)
			CMC_ST_SETTLE:
			begin
				// Let the synchronisers fill before judging the request level
				st_next.cnt = st_reg.cnt + `CMC_CNT_W'(1);
				if (st_reg.cnt >= SETTLE)
				begin
					st_next.cnt = '0;
					if (trig)
						st_next.cal = CMC_ST_IDLE; // RULE_08
					else
						st_next.cal = CMC_ST_POR_WAIT;
				end
			end
			CMC_ST_POR_WAIT:
			begin
				st_next.cnt = st_reg.cnt + `CMC_CNT_W'(1);
				if (st_reg.cnt >= (st_reg.stable[`CMC_PIN_WAIT] ? WAIT_LONG : WAIT_SHORT)) // RULE_06
				begin
					st_next.cnt = '0;
					st_next.cal = CMC_ST_RUN;
					st_next.running = 1'b1;
					st_next.armed = 1'b0;
				end
			end
			CMC_ST_IDLE:
			begin
				if (st_reg.armed && st_reg.high_cnt >= HIGH_MIN)
				begin
					st_next.cal = CMC_ST_RUN; // RULE_07
					st_next.cnt = '0;
					st_next.running = 1'b1; // RULE_10
					st_next.armed = 1'b0;
					st_next.high_cnt = '0;
				end
			end
			CMC_ST_RUN:
			begin
				st_next.cnt = st_reg.cnt + `CMC_CNT_W'(1);
				st_next.armed = 1'b0;
				if (st_reg.cnt >= CAL_RUN - `CMC_CNT_W'(1))
				begin
					st_next.cal = CMC_ST_IDLE;
					st_next.running = 1'b0; // RULE_10
					st_next.cnt = '0;
				end
			end
			default:
			begin
				st_next.cal = CMC_ST_SETTLE;
				st_next.cnt = '0;
				st_next.running = 1'b0;
			end
		endcase

		// Divide-by-4 with optional slave alignment to the reference input
		st_next.div = st_reg.div + 2'b01;
		ref_rise = pin_filt[`CMC_PIN_REFIN] & ~st_reg.stable[`CMC_PIN_REFIN];
		if (extended_control_mode && st_reg.refclk[`CMC_REFCLK_SYNC_EN_BIT] && st_reg.refclk[`CMC_REFCLK_SLAVE_BIT])
		begin
			// A reference edge that comes while a delay still counts is ignored;
			// restarting there would starve alignment for delays of a period or more
			if (ref_rise && !st_reg.align_pend)
			begin
				st_next.align_pend = 1'b1; // RULE_03
				st_next.dly_cnt = st_reg.refclk[`CMC_REFCLK_DELAY_MSB:`CMC_REFCLK_DELAY_LSB];
			end
			else if (st_reg.align_pend)
			begin
				if (st_reg.dly_cnt == 4'h0)
				begin
					st_next.div = 2'b00; // RULE_03
					st_next.align_pend = 1'b0;
				end
				else
					st_next.dly_cnt = st_reg.dly_cnt - 4'h1;
			end
		end
		else
		begin
			st_next.align_pend = 1'b0;
			st_next.dly_cnt = 4'h0;
		end
		// Both outputs share one enable and one divider, so they never drift apart
		ref_on = extended_control_mode & st_reg.refclk[`CMC_REFCLK_OUT_EN_BIT]; // RULE_02
		st_next.ref_a = ref_on & st_next.div[1]; // RULE_01
		st_next.ref_b = ref_on & st_next.div[1]; // RULE_01
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			st_reg <= '0;
			st_reg.ctrl <= `CMC_CTRL_RST;
			st_reg.range_i <= `CMC_RANGE_RST;
			st_reg.range_q <= `CMC_RANGE_RST;
			st_reg.refclk <= `CMC_REFCLK_RST; // RULE_02
			st_reg.stable <= {1'b0, 1'b1, {(`CMC_PIN_N - 2){1'b0}}};
			st_reg.s1 <= {1'b0, 1'b1, {(`CMC_PIN_N - 2){1'b0}}};
			st_reg.s2 <= {1'b0, 1'b1, {(`CMC_PIN_N - 2){1'b0}}};
			st_reg.s3 <= {1'b0, 1'b1, {(`CMC_PIN_N - 2){1'b0}}};
			st_reg.cal <= CMC_ST_SETTLE;
			st_reg.mode.range_i <= `CMC_RANGE_MIN;
			st_reg.mode.range_q <= `CMC_RANGE_MIN;
		end
		else
			st_reg <= st_next;
	end

	assign wb_dat_o = st_reg.dat;
	assign wb_ack_o = st_reg.ack;
	assign selftrim_running = st_reg.running;
	assign ref_clock_out_a = st_reg.ref_a;
	assign ref_clock_out_b = st_reg.ref_b;
	assign divided_clock_phase = st_reg.div;
	assign mode_o = st_reg.mode;

endmodule : cmc_mode_ctrl

/* cmc_mode_ctrl_props.sv */
`timescale 1ns/1ps
module cmc_mode_ctrl_props
	import cmc_pkg::*;
#(
	parameter int CAL_RUN_CYC = 30
)
(
	input wire logic clk_sys, // Sampling clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Acknowledge
	input wire logic selftrim_running, // Calibration busy
	input wire logic ref_clock_out_a, // Reference out A
	input wire logic ref_clock_out_b, // Reference out B
	input wire cmc_mode_t mode_o // Resolved mode
);
	logic [23:0] run_cnt_reg;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// Length of the current calibration, read when the flag falls
	always_ff @(posedge clk_sys)
		run_cnt_reg <= (rstn && selftrim_running) ? run_cnt_reg + 24'h000001 : 24'h000000;
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data outside ack");
	a_ref_off: assert property (!mode_o.extended_control_mode [*2] |-> !ref_clock_out_a)
		else $error("reference out running outside extended mode");
	a_ref_pair: assert property (ref_clock_out_a == ref_clock_out_b)
		else $error("reference outputs differ");
	a_run_length: assert property ($fell(selftrim_running) |-> run_cnt_reg == 24'(CAL_RUN_CYC))
		else $error("calibration length wrong");
	a_bypass_phase: assert property (mode_o.bypass |-> !mode_o.phase90)
		else $error("phase shift active in 1:1 mode");
	a_pd_release: assert property ($fell(mode_o.pd_i) |-> !mode_o.ready_i [*8] ##[1:12] mode_o.ready_i)
		else $error("channel I wake-up timing wrong");
	a_pd_enter: assert property ($rose(mode_o.pd_q) |-> ##[0:3] !mode_o.ready_q)
		else $error("channel Q not powered down");
	a_range_same: assert property (!mode_o.extended_control_mode |-> mode_o.range_i == mode_o.range_q)
		else $error("pin range differs between channels");
endmodule : cmc_mode_ctrl_props

bind cmc_mode_ctrl cmc_mode_ctrl_props #(.CAL_RUN_CYC(CAL_RUN_CYC)) i_props (.clk_sys(clk_sys),
	.rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .selftrim_running(selftrim_running), .ref_clock_out_a(ref_clock_out_a),
	.ref_clock_out_b(ref_clock_out_b), .mode_o(mode_o));

/* cmc_pin_host.sv */
`timescale 1ns/1ps
`include "cmc_map.svh"
module cmc_pin_host
	import cmc_pkg::*;
(
	input wire logic clk_sys, // Board clock
	input wire logic [`CMC_PIN_N-1:0] pins_set, // Requested pin levels
	input wire logic trim_go, // Start a low-then-high request
	output logic [`CMC_PIN_N-1:0] pins, // Pin levels as driven
	output logic selftrim_request, // Calibration request pin
	output logic reference_clock_in // Reference clock from a master
);
	logic [`CMC_PIN_N-1:0] pins_reg = 11'h200;
	logic [7:0] low_cnt_reg = 8'hFF;
	logic [1:0] div_reg = 2'h0;
	always @(posedge clk_sys)
	begin
		pins_reg <= pins_set;
		div_reg <= div_reg + 2'h1;
		if (trim_go)
			low_cnt_reg <= 8'h00;
		else if (low_cnt_reg != 8'hFF)
			low_cnt_reg <= low_cnt_reg + 8'h01;
	end
	assign pins = pins_reg;
	// Low for 12 cycles, past the 10-cycle minimum, so sync lag cannot shorten it
	assign selftrim_request = pins_reg[`CMC_PIN_TRIG] && low_cnt_reg >= 8'h0C;
	// Quarter-rate clock, as another device's reference output would give
	assign reference_clock_in = div_reg[1];
endmodule : cmc_pin_host

/* cmc_pkg.sv */
`include "cmc_map.svh"

package cmc_pkg;

	typedef enum logic [3:0] {
		CMC_ST_SETTLE = 4'h1,
		CMC_ST_POR_WAIT = 4'h2,
		CMC_ST_IDLE = 4'h4,
		CMC_ST_RUN = 4'h8
	} cmc_cal_state_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [5:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} cmc_wb_req_t;

	typedef struct packed {
		logic interleave;
		logic des_q;
		logic pattern;
		logic bypass;
		logic phase90;
		logic [15:0] range_i;
		logic [15:0] range_q;
		logic pd_i;
		logic pd_q;
		logic ready_i;
		logic ready_q;
		logic extended_control_mode;
	} cmc_mode_t;

	typedef struct packed {
		logic [`CMC_PIN_N-1:0] s1;
		logic [`CMC_PIN_N-1:0] s2;
		logic [`CMC_PIN_N-1:0] s3;
		logic [`CMC_PIN_N-1:0] stable;
		logic [15:0] ctrl;
		logic [15:0] range_i;
		logic [15:0] range_q;
		logic [15:0] refclk;
		logic ack;
		logic [31:0] dat;
		cmc_cal_state_t cal;
		logic [`CMC_CNT_W-1:0] cnt;
		logic [`CMC_CNT_W-1:0] low_cnt;
		logic [`CMC_CNT_W-1:0] high_cnt;
		logic armed;
		logic running;
		cmc_mode_t mode;
		logic [15:0] pwr_cnt_i;
		logic [15:0] pwr_cnt_q;
		logic [1:0] div;
		logic ref_a;
		logic ref_b;
		logic [3:0] dly_cnt;
		logic align_pend;
	} cmc_state_t;

endpackage : cmc_pkg

/* tb_cmc_mode_ctrl.sv */
`timescale 1ns/1ps
`include "cmc_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch %0t: got %0h expected %0h", $time, got, exp); end end
module tb_cmc_mode_ctrl;
	import cmc_pkg::*;
	localparam int CAL_RUN = 30;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	cmc_wb_req_t wb = '0;
	logic [`CMC_PIN_N-1:0] pset = 11'h200;
	logic [`CMC_PIN_N-1:0] pins;
	logic trim_go = 1'b0;
	logic trig_pin, refin, wb_ack_o, running, ref_a, ref_b, p;
	logic [31:0] wb_dat_o;
	logic [31:0] r;
	logic [31:0] seed = 32'h00007945;
	logic [15:0] rd;
	logic [1:0] div_ph;
	cmc_mode_t mode_o;
	int errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int regm [16];
	int t_a, t_b, k, n;
	cmc_pin_host i_host (.clk_sys(clk_sys), .pins_set(pset), .trim_go(trim_go), .pins(pins),
		.selftrim_request(trig_pin), .reference_clock_in(refin));
	cmc_mode_ctrl #(.WAIT_SHORT_CYC(20), .WAIT_LONG_CYC(40), .CAL_RUN_CYC(CAL_RUN), .PWRUP_CYC(8))
	i_dut (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb.cyc), .wb_stb_i(wb.stb), .wb_we_i(wb.we),
		.wb_adr_i(wb.adr), .wb_sel_i(wb.sel), .wb_dat_i(wb.dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .dual_edge_sampling_select(pins[0]), .selftrim_wait_select(pins[1]),
		.selftrim_request(trig_pin), .power_down_i(pins[3]), .power_down_q(pins[4]),
		.pattern_output_select(pins[5]), .output_demux_bypass(pins[6]),
		.input_range_select(pins[7]), .output_phase_select(pins[8]),
		.extended_control_enable_n(pins[9]), .reference_clock_in(refin),
		.selftrim_running(running), .ref_clock_out_a(ref_a), .ref_clock_out_b(ref_b),
		.divided_clock_phase(div_ph), .mode_o(mode_o));
	always #2 clk_sys = ~clk_sys;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	// Register model follows the bus: writes only land in extended mode
	task automatic bus(input logic we, input logic [3:0] idx, input logic [15:0] wd);
		wb <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'hF, {16'h0000, wd}};
		do
			@(posedge clk_sys);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o[15:0];
		wb <= '0;
		@(posedge clk_sys);
		if (we && !pset[9] && (idx == 4'h0 || idx == 4'h3 || idx == 4'hB || idx == 4'hE))
			regm[idx] = wd;
		else if (!we && idx != 4'h1)
			`CHK(rd, 16'(regm[idx]))
	endtask : bus
	task automatic set_ecm(input logic on);
		pset[9] <= ~on;
		repeat (12) @(posedge clk_sys);
		if (!on)
			regm = '{0: 0, 3: 32768, 11: 32768, default: 0};
	endtask : set_ecm
	task automatic do_reset(input logic wpin, input logic tpin);
		rstn <= 1'b0;
		pset <= {2'b01, 6'h00, tpin, wpin, 1'b0};
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
	endtask : do_reset
	task automatic wait_cal(output int t);
		int h;
		t = 0;
		h = 0;
		while (running !== 1'b1 && t < 400)
		begin
			@(posedge clk_sys);
			t++;
		end
		while (running === 1'b1 && h < 400)
		begin
			@(posedge clk_sys);
			h++;
		end
		`CHK(h, CAL_RUN)
	endtask : wait_cal
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles > 20000)
		begin
			errors++;
			summarize();
		end
	end
	initial
	begin
		regm[3] = 32768;
		regm[11] = 32768;
		do_reset(1'b0, 1'b0);
		wait_cal(t_a);
		do_reset(1'b1, 1'b0);
		wait_cal(t_b);
		`CHK(t_b - t_a, 20)
		do_reset(1'b0, 1'b1);
		n = 0;
		repeat (100)
		begin
			@(posedge clk_sys);
			n += (running !== 1'b0);
		end
		`CHK(n, 0)
		trim_go <= 1'b1;
		@(posedge clk_sys);
		trim_go <= 1'b0;
		wait_cal(t_a);
		$display("test calibration done");
		for (k = 0; k < 8; k++)
		begin
			r = rnd();
			pset[8:3] <= r[5:0];
			pset[0] <= r[6];
			repeat (24) @(posedge clk_sys);
			`CHK(mode_o.interleave, r[6])
			`CHK(mode_o.pattern, r[2])
			`CHK(mode_o.bypass, r[3])
			`CHK(mode_o.phase90, r[5] & ~r[3])
			`CHK(mode_o.pd_i, r[0])
			`CHK(mode_o.ready_q, ~r[1])
			`CHK(mode_o.range_i, r[4] ? 16'h8000 : 16'h0000)
			`CHK(mode_o.extended_control_mode, 1'b0)
		end
		$display("test pin mode done");
		pset[4:2] <= 3'h0;
		set_ecm(1'b1);
		for (k = 0; k < 16; k++)
			bus(1'b0, k[3:0], 16'h0000);
		bus(1'b1, 4'h2, 16'hFFFF);
		bus(1'b0, 4'h2, 16'h0000);
		bus(1'b1, 4'h0, 16'h8000);
		wait_cal(t_a);
		bus(1'b1, 4'h0, 16'h0000);
		for (k = 0; k < 8; k++)
		begin
			r = rnd();
			pset[8:5] <= r[24:21];
			pset[0] <= r[25];
			bus(1'b1, 4'h0, r[15:0] & 16'h7FFF);
			bus(1'b1, 4'h3, r[31:16]);
			bus(1'b1, 4'hB, r[15:0]);
			repeat (24) @(posedge clk_sys);
			`CHK(mode_o.interleave, r[7])
			`CHK(mode_o.pattern, r[12])
			`CHK(mode_o.bypass, r[22])
			`CHK(mode_o.phase90, r[14] & ~r[22])
			`CHK({mode_o.pd_i, mode_o.pd_q}, r[11:10])
			`CHK({mode_o.range_i, mode_o.range_q}, r)
			bus(1'b0, 4'h0, 16'h0000);
			`CHK(mode_o.des_q, r[6])
			bus(1'b0, 4'h1, 16'h0000);
			`CHK(rd, {8'h00, 1'b1, ~r[10], ~r[11], r[14] & ~r[22], r[22], r[12], r[7], 1'b0})
		end
		$display("test extended mode done");
		bus(1'b1, 4'hE, 16'h0002);
		repeat (8) @(posedge clk_sys);
		n = 0;
		p = ref_a;
		repeat (16)
		begin
			@(posedge clk_sys);
			n += (ref_a !== p);
			p = ref_a;
		end
		`CHK(n, 8)
		bus(1'b1, 4'hE, 16'h0000);
		repeat (4) @(posedge clk_sys);
		`CHK(ref_a, 1'b0)
		// Slave alignment: each cycle of delay shifts the divider phase back by one
		for (k = 0; k < 6; k++)
		begin
			bus(1'b1, 4'hE, {4'h0, k[3:0], 8'h05});
			repeat (32) @(posedge clk_sys);
			n = -1;
			repeat (8)
			begin
				p = refin;
				@(posedge clk_sys);
				if (refin && !p && n < 0)
					n = div_ph;
			end
			if (k == 0)
				t_a = n;
			else
				`CHK(n, (t_a - k + 8) % 4)
		end
		bus(1'b1, 4'hE, 16'h0002);
		set_ecm(1'b0);
		`CHK(ref_a, 1'b0)
		bus(1'b1, 4'h3, 16'h1234);
		set_ecm(1'b1);
		bus(1'b0, 4'hE, 16'h0000);
		bus(1'b0, 4'h3, 16'h0000);
		$display("test reference clock done");
		summarize();
	end
endmodule : tb_cmc_mode_ctrl
